// *** hw/i2c_resv_consts.svh ***
// Constants for the start-reservation and bus-state block
// Behaviour
// RULE1: Reservation accepted between start seen and stop.
// RULE2: Software writes address after stop interrupt.
// RULE3: Reservation off: busy-bus start is rejected.
// RULE4: Lost arbitration or released extension: bus unused. Code: a start still waits for bus_busy_flag clear.
// RULE5: Start result flag reports generated or rejected.
// RULE6: Result valid after 6/6/12/3 clocks.
// RULE7: Initial start not allowed: busy on enable.
// RULE8: Software releases bus with stop first.
// RULE9: Initial start allowed: released on enable.
// RULE10: Enable with SDA low, SCL high: start seen.
// RULE11: Software joins busy bus via release bit.
// RULE12: Change clock select only while disabled.
// RULE13: No repeat request while bit pending.
// RULE14: Reserved transfer starts on data after stop interrupt.
// RULE15: Polling master status needs no stop interrupt.
// RULE16: Bus free after levels high one frame. Code: bus_busy_flag clears only on a stop or on disable.
// RULE17: Master reads master status each interrupt.
// RULE18: Slave inspects status each interrupt.
// RULE19: Recover stuck SDA by pulsing SCL.
// RULE20: Reservation on, bus free: start immediately.
// RULE21: Software waits before checking master status.
// RULE22: Start request bit self-clears when resolved.
`ifndef I2C_RESV_CONSTS_SVH
`define I2C_RESV_CONSTS_SVH
`define ADDR_CONTROL   8'h00
`define ADDR_STATUS    8'h04
`define ADDR_FLAG      8'h08
`define ADDR_CLKSEL    8'h0c
`define ADDR_SHIFT     8'h10
`define CTL_ENABLE     7
`define CTL_RELEASE    6
`define CTL_STOPIE     4
`define CTL_START      1
`define CTL_STOP       0
`define STS_MASTER     7
`define STS_START_SEEN 1
`define STS_STOP_SEEN  0
`define FLG_RESULT     7
`define FLG_BUSY       6
`define FLG_INIT_ALLOW 1
`define FLG_RSV_DIS    0
`define STS_SCL_LEVEL  5
`define STS_SDA_LEVEL  4
`define SETTLE_00      4'h6
`define SETTLE_01      4'h6
`define SETTLE_10      4'hc
`define SETTLE_11      4'h3
`define QUARTER_DIV    8'h0a
`endif

// *** hw/i2c_resv_pkg.sv ***
// Types for the start-reservation block
`default_nettype none
package i2c_resv_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_START_A, ST_START_B, ST_WAIT, ST_STOP_A, ST_STOP_B} ctl_state_t;
endpackage
`default_nettype wire

// *** hw/bus_cond_detect.sv ***
// Synchroniser and start/stop detector for the two bus lines
`default_nettype none
module bus_cond_detect (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Raw pin levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Clean levels and events
  output logic      scl_level,
  output logic      sda_level,
  output logic      start_evt,
  output logic      stop_evt
);
  logic scl_m, sda_m, sda_prev;

  // Two flops per line; first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_m     <= 1'b1;
      sda_m     <= 1'b1;
      scl_level <= 1'b1;
      sda_level <= 1'b1;
    end else begin
      scl_m     <= scl_in;
      sda_m     <= sda_in;
      scl_level <= scl_m;
      sda_level <= sda_m;
    end
  end

  // Edge history of the clean data line
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sda_prev <= 1'b1;
    end else begin
      sda_prev <= sda_level;
    end
  end

  // SDA edge with SCL high marks start or stop
  assign start_evt = scl_level & sda_prev & ~sda_level;
  assign stop_evt  = scl_level & ~sda_prev & sda_level;
endmodule // bus_cond_detect
`default_nettype wire

// *** hw/i2c_start_reservation_busstate.sv ***
// Start request, reservation and bus-state logic behind an AHB-Lite slave
`include "i2c_resv_consts.svh"
`default_nettype none
module i2c_start_reservation_busstate
  import i2c_resv_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Bus pins, open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_oe,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             sda_out,
  // Stop-condition interrupt line
  output logic             transfer_interrupt
);
  ctl_state_t state;
  logic       scl_level, sda_level, start_evt, stop_evt;
  logic       operation_enable_bit, release_bus_bit, stop_interrupt_enable;
  logic       start_request_bit, stop_request_bit;
  logic       start_seen_flag, stop_seen_flag, master_status_flag;
  logic       start_result_flag, bus_busy_flag, reservation_disable, initial_start_allow;
  logic       reserved, ignore_traffic, addr_written;
  logic [1:0] clock_select;
  logic [7:0] serial_shift_register;
  logic [3:0] settle_cnt, settle_len;
  logic [7:0] div_cnt;
  logic [4:0] bit_cnt;
  logic       tick;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       rd_sel;
  logic [7:0] rd_addr;
  logic       we, req_start, req_stop, enable_rise, bus_free;

  bus_cond_detect u_det (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_level (scl_level),
    .sda_level (sda_level),
    .start_evt (start_evt),
    .stop_evt  (stop_evt)
  );

  // Address phase capture; every access completes with no wait state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_sel  <= 1'b0;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= hsel & hready & htrans[1] & hwrite;
      rd_sel  <= hsel & hready & htrans[1] & ~hwrite;
      wr_addr <= haddr;
      rd_addr <= haddr;
    end
  end

  assign we          = wr_pend;
  assign req_start   = we && wr_addr == `ADDR_CONTROL && hwdata[`CTL_START];
  assign req_stop    = we && wr_addr == `ADDR_CONTROL && hwdata[`CTL_STOP];
  assign enable_rise = we && wr_addr == `ADDR_CONTROL && hwdata[`CTL_ENABLE] && !operation_enable_bit;
  assign bus_free    = !bus_busy_flag;

  // Read data is registered so hrdata comes from a flop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr == `ADDR_CONTROL) begin
        hrdata <= {24'h0, operation_enable_bit, release_bus_bit, 1'b0, stop_interrupt_enable,
                   2'b00, start_request_bit, stop_request_bit};
      end else if (haddr == `ADDR_STATUS) begin
        hrdata <= {24'h0, master_status_flag, 1'b0, scl_level, sda_level, 2'b00, start_seen_flag, stop_seen_flag};
      end else if (haddr == `ADDR_FLAG) begin
        hrdata <= {24'h0, start_result_flag, bus_busy_flag, 4'h0, initial_start_allow, reservation_disable};
      end else if (haddr == `ADDR_CLKSEL) begin
        hrdata <= {30'h0, clock_select};
      end else if (haddr == `ADDR_SHIFT) begin
        hrdata <= {24'h0, serial_shift_register};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Software control fields
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      operation_enable_bit  <= 1'b0;
      stop_interrupt_enable <= 1'b0;
      reservation_disable   <= 1'b0;
      initial_start_allow   <= 1'b0;
      clock_select          <= 2'b00;
    end else if (we) begin
      if (wr_addr == `ADDR_CONTROL) begin
        operation_enable_bit  <= hwdata[`CTL_ENABLE];
        stop_interrupt_enable <= hwdata[`CTL_STOPIE];
      end else if (wr_addr == `ADDR_FLAG) begin
        reservation_disable <= hwdata[`FLG_RSV_DIS];
        initial_start_allow <= hwdata[`FLG_INIT_ALLOW];
      end else if (wr_addr == `ADDR_CLKSEL && !operation_enable_bit) begin
        // Divider only changes while disabled, avoiding a glitched rate
        clock_select <= hwdata[1:0];
      end
    end
  end

  // Shift register write; address only counts once stop was signalled
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      serial_shift_register <= 8'h00;
      addr_written          <= 1'b0;
    end else if (we && wr_addr == `ADDR_SHIFT) begin
      serial_shift_register <= hwdata[7:0];
      // RULE14 data after stop interrupt
      addr_written          <= reserved && transfer_interrupt;
    end else if (state == ST_START_A) begin
      addr_written <= 1'b0;
    end
  end

  // Release request: set ignore_traffic until the next stop or disable
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      release_bus_bit <= 1'b0;
      ignore_traffic  <= 1'b0;
    end else begin
      release_bus_bit <= 1'b0;
      if (we && wr_addr == `ADDR_CONTROL && hwdata[`CTL_RELEASE]) begin
        // RULE4 release sets ignore_traffic; a start still needs bus_busy_flag clear
        ignore_traffic  <= 1'b1;
        release_bus_bit <= 1'b1;
      end else if (stop_evt || !operation_enable_bit) begin
        ignore_traffic <= 1'b0;
      end
    end
  end

  // Bus busy and seen flags
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_busy_flag   <= 1'b0;
      start_seen_flag <= 1'b0;
      stop_seen_flag  <= 1'b0;
    end else if (enable_rise) begin
      // RULE7 busy when initial start barred
      // RULE9 released when initial start allowed
      bus_busy_flag   <= !initial_start_allow;
      // RULE10 low data under high clock is a start
      start_seen_flag <= scl_level && !sda_level;
      stop_seen_flag  <= 1'b0;
    end else if (!operation_enable_bit) begin
      bus_busy_flag   <= 1'b0;
      start_seen_flag <= 1'b0;
      stop_seen_flag  <= 1'b0;
    end else if (start_evt) begin
      // Start on the lines marks the bus busy
      bus_busy_flag   <= 1'b1;
      start_seen_flag <= 1'b1;
      stop_seen_flag  <= 1'b0;
    end else if (stop_evt) begin
      bus_busy_flag   <= 1'b0;
      start_seen_flag <= 1'b0;
      stop_seen_flag  <= 1'b1;
    end
  end

  // Transfer-rate divider gives quarter-bit ticks
  always_ff @(posedge clk_sys) begin
    if (!resetn || !operation_enable_bit) begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end else if (div_cnt == (`QUARTER_DIV << clock_select) - 8'h01) begin
      div_cnt <= 8'h00;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick    <= 1'b0;
    end
  end

  // RULE6 settle time per clock select
  always_comb begin
    if (clock_select == 2'b00) begin
      settle_len = `SETTLE_00;
    end else if (clock_select == 2'b01) begin
      settle_len = `SETTLE_01;
    end else if (clock_select == 2'b10) begin
      settle_len = `SETTLE_10;
    end else begin
      settle_len = `SETTLE_11;
    end
  end

  // Request handling state machine
  always_ff @(posedge clk_sys) begin
    if (!resetn || !operation_enable_bit) begin
      state              <= ST_IDLE;
      start_request_bit  <= 1'b0;
      stop_request_bit   <= 1'b0;
      start_result_flag  <= 1'b0;
      master_status_flag <= 1'b0;
      reserved           <= 1'b0;
      settle_cnt         <= 4'h0;
      bit_cnt            <= 5'h00;
    end else begin
      if (req_stop) begin
        stop_request_bit <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (req_start) begin
            start_request_bit <= 1'b1;
            start_result_flag <= 1'b0;
            settle_cnt        <= 4'h1;
            state             <= ST_SETTLE;
          end else if (stop_request_bit || req_stop) begin
            bit_cnt <= 5'h00;
            state   <= ST_STOP_A;
          end else if (reserved && addr_written && bus_free) begin
            // RULE1 pending reservation fires after stop
            bit_cnt <= 5'h00;
            state   <= ST_START_A;
          end
        end
        ST_SETTLE: begin
          if (settle_cnt == settle_len) begin
            // RULE22 request bit clears when resolved
            start_request_bit <= 1'b0;
            if (bus_free || ignore_traffic && !bus_busy_flag) begin
              // RULE20 immediate start on a free bus
              // RULE5 result reports generated start
              start_result_flag  <= 1'b1;
              master_status_flag <= 1'b1;
              bit_cnt            <= 5'h00;
              state              <= ST_START_A;
            end else if (!reservation_disable && start_seen_flag) begin
              // RULE1 reservation held until the stop
              reserved <= 1'b1;
              state    <= ST_IDLE;
            end else begin
              // RULE3 rejected, no start generated
              start_result_flag <= 1'b0;
              state             <= ST_IDLE;
            end
          end else begin
            settle_cnt <= settle_cnt + 4'h1;
          end
        end
        ST_START_A: begin
          if (tick) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h01) begin
              state <= ST_START_B;
            end
          end
        end
        ST_START_B: begin
          if (tick) begin
            master_status_flag <= 1'b1;
            reserved           <= 1'b0;
            state              <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Holds SCL low; reserved start awaits an address write
          if (reserved && addr_written) begin
            bit_cnt <= 5'h00;
            state   <= ST_START_A;
          end else if (stop_request_bit) begin
            bit_cnt <= 5'h00;
            state   <= ST_STOP_A;
          end
        end
        ST_STOP_A: begin
          if (tick) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h01) begin
              state <= ST_STOP_B;
            end
          end
        end
        ST_STOP_B: begin
          if (tick) begin
            stop_request_bit   <= 1'b0;
            master_status_flag <= 1'b0;
            state              <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers: open drain, outputs always low when enabled
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= (state == ST_START_B) || (state == ST_WAIT) || (state == ST_STOP_A && bit_cnt == 5'h00);
      sda_oe  <= (state == ST_START_A && bit_cnt != 5'h00) || (state == ST_START_B) || (state == ST_WAIT)
                 || (state == ST_STOP_A);
    end
  end

  // Stop interrupt line, cleared by reading the status register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      transfer_interrupt <= 1'b0;
    end else if (stop_evt && stop_interrupt_enable && operation_enable_bit) begin
      transfer_interrupt <= 1'b1;
    end else if (rd_sel && rd_addr == `ADDR_STATUS) begin
      transfer_interrupt <= 1'b0;
    end
  end
endmodule // i2c_start_reservation_busstate
`default_nettype wire

// *** bench/i2c_resv_monitor.sv ***
// Port checker for the start reservation block
`include "i2c_resv_consts.svh"
`default_nettype none
module i2c_resv_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Bus slave side
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Line side
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        scl_out,
  input wire logic        sda_out,
  input wire logic        transfer_interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic       ap;
  logic       wr_ctl;
  logic       en_q;
  logic       sda_q;
  logic [3:0] rd_hist;
  logic [7:0] stop_hist;
  // Address phase accepted at this edge
  assign ap = hsel & hready & htrans[1];
  // Shadow of the enable bit, landing with the design's own copy
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_ctl <= 1'b0;
      en_q   <= 1'b0;
    end else begin
      wr_ctl <= ap & hwrite & (haddr == `ADDR_CONTROL);
      if (wr_ctl) begin
        en_q <= hwdata[`CTL_ENABLE];
      end
    end
  end
  // Recent status reads and stops; long enough to cover the pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sda_q     <= 1'b1;
      rd_hist   <= 4'h0;
      stop_hist <= 8'h00;
    end else begin
      sda_q     <= sda_in;
      rd_hist   <= {rd_hist[2:0], ap & !hwrite & (haddr == `ADDR_STATUS)};
      stop_hist <= {stop_hist[6:0], scl_in & sda_in & !sda_q};
    end
  end
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_no_wait: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  chk_od_drive: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
  chk_irq_after_stop: assert property ($rose(transfer_interrupt) |-> |stop_hist)
    else $error("interrupt without stop");
  chk_irq_clear_read: assert property ($fell(transfer_interrupt) |-> |rd_hist)
    else $error("interrupt cleared without read");
  chk_rdata_on_read: assert property (!$stable(hrdata) |-> $past(ap & !hwrite))
    else $error("read data moved without read");
  chk_oe_needs_en: assert property ($rose(sda_oe) || $rose(scl_oe) |-> en_q)
    else $error("line pulled while disabled");
  chk_off_released: assert property (!en_q [*3] |-> !sda_oe && !scl_oe)
    else $error("line held after disable");
  cov_irq: cover property ($rose(transfer_interrupt));
  cov_start: cover property ($rose(sda_oe));
  cov_stop: cover property (stop_hist[0]);
endmodule // i2c_resv_monitor
bind i2c_start_reservation_busstate i2c_resv_monitor i2c_resv_monitor_inst (
  .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .scl_in, .sda_in, .scl_oe, .sda_oe, .scl_out, .sda_out, .transfer_interrupt
);
`default_nettype wire

// *** bench/peer_master.sv ***
// Other bus master: start and stop on the shared open-drain lines
`default_nettype none
module peer_master (
  // High = line pulled low
  output var logic scl_low,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // lines idle high between frames, clock still
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Start, then clock held low so the bus stays busy
  task automatic start_cond();
    #100 sda_low = 1'b1;
    #100 scl_low = 1'b1;
  endtask
  // clock raised, then held data released
  task automatic stop_cond();
    #100 sda_low = 1'b1;
    #100 scl_low = 1'b0;
    #100 sda_low = 1'b0;
  endtask
  // Data low with clock high, as in a transfer under way
  task automatic data_low();
    #100 sda_low = 1'b1;
  endtask
endmodule // peer_master
`default_nettype wire

// *** bench/i2c_start_reservation_busstate_tb.sv ***
// Testbench for the start reservation block
`include "i2c_resv_consts.svh"
`default_nettype none
module i2c_start_reservation_busstate_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} row_t;
  logic clk_sys = 1'b0, resetn = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hready, scl_oe, sda_oe, scl_low, sda_low, irq;
  int error_cnt = 0, cmp_count = 0;
  int settle[4] = '{6, 6, 12, 3};
  row_t rows[5] = '{'{`ADDR_CLKSEL, 2, 3, 2}, '{`ADDR_CLKSEL, 1, 3, 1},
    '{`ADDR_FLAG, 3, 3, 3}, '{8'h20, 32'hff, 32'hffffffff, 0}, '{`ADDR_FLAG, 0, 3, 0}};
  always #12.5 clk_sys = ~clk_sys;
  i2c_start_reservation_busstate i2c_start_reservation_busstate_inst (
    .clk_sys, .resetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp(), .scl_in(~(scl_oe | scl_low)),
    .sda_in(~(sda_oe | sda_low)), .scl_oe, .sda_oe, .scl_out(), .sda_out(), .transfer_interrupt(irq));
  peer_master peer_master_inst (.scl_low, .sda_low);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // One whole-word transfer; each phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check(x & m, e);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    #(25 * 20000);
    error_cnt++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].m, rows[i].e);
    end
    $display("register rows done");
    wr(`ADDR_CONTROL, 32'h80);
    rd(`ADDR_FLAG, 32'h40, 32'h40);
    wr(`ADDR_CONTROL, 32'h81);
    repeat (80) @(posedge clk_sys);
    rd(`ADDR_FLAG, 32'h40, 0);
    rd(`ADDR_CONTROL, 1, 0);
    wr(`ADDR_CLKSEL, 3);
    rd(`ADDR_CLKSEL, 3, 1);
    // Settle time for every clock select, bus free
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CONTROL, 0);
      wr(`ADDR_CLKSEL, i);
      wr(`ADDR_FLAG, 2);
      wr(`ADDR_CONTROL, 32'h80);
      rd(`ADDR_FLAG, 32'h40, 0);
      wr(`ADDR_CONTROL, 32'h82);
      repeat (settle[i]) @(posedge clk_sys);
      rd(`ADDR_FLAG, 32'h80, 32'h80);
      rd(`ADDR_CONTROL, 2, 0);
      rd(`ADDR_STATUS, 32'h80, 32'h80);
    end
    $display("settle done");
    // Reservation off, bus taken by the peer: refused
    wr(`ADDR_CONTROL, 0);
    wr(`ADDR_CLKSEL, 0);
    wr(`ADDR_FLAG, 3);
    wr(`ADDR_CONTROL, 32'h80);
    peer_master_inst.start_cond();
    wr(`ADDR_CONTROL, 32'h82);
    repeat (6) @(posedge clk_sys);
    rd(`ADDR_FLAG, 32'h80, 0);
    rd(`ADDR_CONTROL, 2, 0);
    check(sda_oe, 0);
    peer_master_inst.stop_cond();
    $display("refusal done");
    // Reservation held until stop, then address write starts the transfer
    wr(`ADDR_CONTROL, 0);
    wr(`ADDR_FLAG, 2);
    wr(`ADDR_CONTROL, 32'h90);
    peer_master_inst.start_cond();
    rd(`ADDR_STATUS, 2, 2);
    wr(`ADDR_CONTROL, 32'h92);
    repeat (12) @(posedge clk_sys);
    rd(`ADDR_STATUS, 32'h80, 0);
    peer_master_inst.stop_cond();
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clk_sys);
    check(irq, 1);
    wr(`ADDR_SHIFT, 32'ha0);
    repeat (46) @(posedge clk_sys);
    rd(`ADDR_STATUS, 32'h80, 32'h80);
    rd(`ADDR_FLAG, 32'h40, 32'h40);
    repeat (3) @(posedge clk_sys);
    check(irq, 0);
    $display("reservation done");
    // Enable with data already low and clock high
    wr(`ADDR_CONTROL, 0);
    peer_master_inst.data_low();
    wr(`ADDR_CONTROL, 32'h80);
    rd(`ADDR_STATUS, 2, 2);
    wr(`ADDR_CONTROL, 32'hc0);
    peer_master_inst.stop_cond();
    repeat (4) @(posedge clk_sys);
    check(irq, 0);
    rd(`ADDR_STATUS, 3, 1);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`ADDR_CONTROL, 32'h80, 0);
    rd(`ADDR_CLKSEL, 3, 0);
    $display("join and reset done");
    results();
  end
endmodule // i2c_start_reservation_busstate_tb
`default_nettype wire
